// file: rtl/ccr_card_regs.sv
// pin state and socket/copy registers with the read-only card information table
`timescale 1ns/1ps
// Functional notes
// - change flag bit 5 sets whenever ready readback bit changes state while the mask bit is clear.
// - host may write the change flag directly, clearing or setting it.
// - reading pin state bit 1 returns current card ready pin level.
// - written bit 1 masks hardware setting of the change flag, never alters the readback.
// - pin state resets to 0ch; bits 3,2 read one; 7,6,4,0 read zero.
// - pin state register decoded at attribute offset 204h.
// - socket/copy register at 206h, reset 00h, copy number in bit 4.
// - information table bytes read from attribute offset zero upward.
// - offset 000h returns 01h, offset 002h returns link 04h.
// - offset 004h encodes I/O type, no write protect, extended speed.
// - offset 008h returns 01h, one 2k unit of space.
// - offset 00ch returns 1ch, other-conditions tuple code.
// - offset 010h returns 02h, 3 V and wait unused.
// - offset 012h returns d9h, I/O type at 250 ns speed.
// - offset 018h returns 18h, common memory identifier tuple.
// - offset 01ah returns identifier link length 02h.
// - set change flag raises status flag; status pin low in I/O mode with enable.
// - power-down control change shows busy until power state entered.
// ------------------------------------------------------------
// host pin timing
// ------------------------------------------------------------
// all host pins pass two sync stages; a read shows on the data
// outputs at the third edge after the pins settle
// hosts hold strobes low, and then high, for three clocks at least
// address and data must stay put across the strobe plus three clocks
// a write acts when the synced write strobe rises, using the
// address and data seen in its last low cycle
// the ready readback shows busy from any power-down control change
// until the core reports that the new power state is reached
// a readback change wins over a host write landing in the same cycle,
// so an event is never lost to a late clear
// the mask bit only stops hardware setting of the change flag; the
// host can still write the flag, and the mask itself is not readable
module ccr_card_regs
    import ccr_pkg::*;
#(
    parameter logic [7:0] MANUF_ID   = 8'h5a,  // arbitrary neutral value
    parameter logic [7:0] MANUF_DEV  = 8'h01   // arbitrary neutral value
)
(
    // clock and reset
    input  wire logic              REF_CLK,
    input  wire logic              RST,
    // host attribute memory pins
    input  wire logic [CCR_AW-1:0] ADDR,
    input  wire logic [7:0]        DIN,
    input  wire logic              CE1_N,
    input  wire logic              REG_N,
    input  wire logic              OE_N,
    input  wire logic              WE_N,
    output logic [7:0]             DOUT,
    output logic                   DOUT_OE,
    // card core status
    input  wire logic              CORE_READY,
    input  wire logic              POWER_DOWN_CONTROL,
    input  wire logic              POWER_STATE_REACHED,
    input  wire logic              IO_MODE,
    input  wire logic              CHANGE_SIGNAL_ENABLE,
    // card status outputs
    output logic                   READY_PIN,
    output logic                   STATUS_CHANGED_FLAG,
    output logic                   STATUS_CHANGE_PIN_N
);

    // ------------------------------------------------------------
    // pin synchronisers
    // ------------------------------------------------------------
    logic [CCR_AW-1:0] addr_s1_q;
    logic [CCR_AW-1:0] addr_s2_q;
    logic [7:0]        din_s1_q;
    logic [7:0]        din_s2_q;
    logic [3:0]        ctl_s1_q;  // ce1_n, reg_n, oe_n, we_n
    logic [3:0]        ctl_s2_q;
    logic              we_s3_q;   // edge stage, fed from the second flop only

    // address and data: two stages, nothing reads the first
    always_ff @(posedge REF_CLK or posedge RST)
    begin
        if (RST)
        begin
            addr_s1_q <= '0;
            addr_s2_q <= '0;
            din_s1_q  <= 8'h00;
            din_s2_q  <= 8'h00;
        end
        else
        begin
            addr_s1_q <= ADDR;
            addr_s2_q <= addr_s1_q;
            din_s1_q  <= DIN;
            din_s2_q  <= din_s1_q;
        end
    end

    // strobes reset to their idle high level, so no false
    // write edge follows reset
    always_ff @(posedge REF_CLK or posedge RST)
    begin
        if (RST)
        begin
            ctl_s1_q <= 4'hf;
            ctl_s2_q <= 4'hf;
            we_s3_q  <= 1'b1;
        end
        else
        begin
            ctl_s1_q <= {CE1_N, REG_N, OE_N, WE_N};
            ctl_s2_q <= ctl_s1_q;
            we_s3_q  <= ctl_s2_q[0];
        end
    end

    // ------------------------------------------------------------
    // write capture
    // ------------------------------------------------------------
    // address and data are held while the strobe is low, so the
    // rising edge acts on values seen inside the strobe window
    logic [CCR_AW-1:0] wr_addr_q;
    logic [7:0]        wr_data_q;
    logic              wr_sel_q;
    wire logic         attr_sel = ~ctl_s2_q[3] & ~ctl_s2_q[2];
    wire logic         we_low   = ~ctl_s2_q[0];
    wire logic         wr_done  = ~we_s3_q & ctl_s2_q[0] & wr_sel_q;

    // hold the last sampled write cycle
    always_ff @(posedge REF_CLK or posedge RST)
    begin
        if (RST)
        begin
            wr_addr_q <= '0;
            wr_data_q <= 8'h00;
            wr_sel_q  <= 1'b0;
        end
        else if (we_low)
        begin
            wr_addr_q <= addr_s2_q;
            wr_data_q <= din_s2_q;
            wr_sel_q  <= attr_sel;
        end
    end

    // ------------------------------------------------------------
    // write decode
    // ------------------------------------------------------------
    // one decode for both directions: bit 0 pin state, bit 1 socket
    function automatic logic [1:0] reg_hit(input logic [CCR_AW-1:0] a);
        logic [1:0] h;
        h    = 2'b00;
        h[0] = (a == CCR_PIN_STATE_OFS);
        h[1] = (a == CCR_SOCKET_OFS);
        return h;
    endfunction

    // table locations have no write strobe at all
    wire logic [1:0] wr_hit    = reg_hit(wr_addr_q);
    wire logic       wr_pin    = wr_done & wr_hit[0];
    wire logic       wr_socket = wr_done & wr_hit[1];

    // ------------------------------------------------------------
    // power state busy tracking
    // ------------------------------------------------------------
    // power tracking and pin state storage
    logic pwd_prev_q;
    logic busy_q;
    logic rdy_q;
    logic chg_q;
    logic mask_q;
    logic copy_q;
    wire logic pwd_edge  = POWER_DOWN_CONTROL ^ pwd_prev_q;
    wire logic busy_d    = pwd_edge | (busy_q & ~POWER_STATE_REACHED);
    wire logic rdy_d     = CORE_READY & ~busy_d;

    // busy holds from the control change until the core reports arrival
    always_ff @(posedge REF_CLK or posedge RST)
    begin
        if (RST)
        begin
            pwd_prev_q <= 1'b0;
            busy_q     <= 1'b0;
            rdy_q      <= 1'b0;
        end
        else
        begin
            pwd_prev_q <= POWER_DOWN_CONTROL;
            busy_q     <= busy_d;
            rdy_q      <= rdy_d;
        end
    end

    // ------------------------------------------------------------
    // change flag, mask and copy number
    // ------------------------------------------------------------
    // a readback change in the same cycle as a host write wins
    wire logic rdy_event = (rdy_d ^ rdy_q) & ~mask_q;
    wire logic chg_d     = rdy_event ? 1'b1 :
                           wr_pin    ? wr_data_q[CCR_CHG_BIT] : chg_q;
    wire logic mask_d    = wr_pin    ? wr_data_q[CCR_RDY_BIT] : mask_q;
    wire logic copy_d    = wr_socket ? wr_data_q[CCR_COPY_BIT] : copy_q;

    // pin state and socket registers
    always_ff @(posedge REF_CLK or posedge RST)
    begin
        if (RST)
        begin
            chg_q  <= CCR_PIN_STATE_RST[CCR_CHG_BIT];
            mask_q <= 1'b0;
            copy_q <= CCR_SOCKET_RST[CCR_COPY_BIT];
        end
        else
        begin
            chg_q  <= chg_d;
            mask_q <= mask_d;
            copy_q <= copy_d;
        end
    end

    // ------------------------------------------------------------
    // information table
    // ------------------------------------------------------------
    // odd bytes and anything past the identifier read as zero
    function automatic logic [7:0] cis_byte(input logic [CCR_AW-1:0] a);
        logic [7:0] v;
        v = CCR_UNMAPPED;
        unique case (a)
            11'h000: v = CCR_TPL_DEVICE;
            11'h002: v = CCR_LINK_4;
            11'h004: v = {CCR_DEV_TYPE_IO, CCR_WPS_ABSENT, CCR_SPEED_EXT};
            11'h006: v = CCR_EXT_SPEED;
            11'h008: v = CCR_SIZE_2K;
            11'h00a: v = CCR_END_MARK;
            11'h00c: v = CCR_TPL_DEVICE_OC;
            11'h00e: v = CCR_LINK_4;
            11'h010: v = CCR_OC_3V_NOWAIT;
            11'h012: v = {CCR_DEV_TYPE_IO, CCR_WPS_ABSENT, CCR_SPEED_250NS};
            11'h014: v = CCR_SIZE_2K;
            11'h016: v = CCR_END_MARK;
            11'h018: v = CCR_TPL_JEDEC_C;
            11'h01a: v = CCR_LINK_2;
            11'h01c: v = MANUF_ID;
            11'h01e: v = MANUF_DEV;
            default: v = CCR_UNMAPPED;
        endcase
        return v;
    endfunction

    // ------------------------------------------------------------
    // read mux
    // ------------------------------------------------------------
    wire logic [7:0] pin_rd    = CCR_PIN_STATE_ONE
                               | ({7'h00, chg_q} << CCR_CHG_BIT)
                               | ({7'h00, rdy_q} << CCR_RDY_BIT);
    wire logic [7:0] socket_rd = {7'h00, copy_q} << CCR_COPY_BIT;
    wire logic       rd_act    = attr_sel & ~ctl_s2_q[1];
    wire logic [1:0] rd_hit    = reg_hit(addr_s2_q);
    wire logic [7:0] rd_data   = rd_hit[0]                        ? pin_rd :
                                 rd_hit[1]                        ? socket_rd :
                                 (addr_s2_q <  CCR_CIS_LIMIT)     ? cis_byte(addr_s2_q) :
                                 CCR_UNMAPPED;
    wire logic       status_change_pin_n  = ~(chg_q & IO_MODE & CHANGE_SIGNAL_ENABLE);

    // ------------------------------------------------------------
    // read data outputs
    // ------------------------------------------------------------
    // zero whenever the card is not driving the data pins
    always_ff @(posedge REF_CLK or posedge RST)
    begin
        if (RST)
        begin
            DOUT    <= 8'h00;
            DOUT_OE <= 1'b0;
        end
        else
        begin
            DOUT    <= rd_act ? rd_data : 8'h00;
            DOUT_OE <= rd_act;
        end
    end

    // ------------------------------------------------------------
    // status outputs
    // ------------------------------------------------------------
    // ready pin mirrors the readback; the flag copy takes the next
    // value so it never trails the register
    always_ff @(posedge REF_CLK or posedge RST)
    begin
        if (RST)
        begin
            READY_PIN           <= 1'b0;
            STATUS_CHANGED_FLAG <= 1'b0;
            STATUS_CHANGE_PIN_N <= 1'b1;
        end
        else
        begin
            READY_PIN           <= rdy_d;
            STATUS_CHANGED_FLAG <= chg_d;
            STATUS_CHANGE_PIN_N <= status_change_pin_n;
        end
    end

endmodule

// file: rtl/ccr_pkg.sv
// constants for the card configuration registers and the information table
package ccr_pkg;

    // ------------------------------------------------------------
    // attribute memory map
    // ------------------------------------------------------------
    localparam int         CCR_AW            = 11;
    localparam logic [10:0] CCR_PIN_STATE_OFS = 11'h204;
    localparam logic [10:0] CCR_SOCKET_OFS    = 11'h206;
    localparam logic [10:0] CCR_CIS_BASE      = 11'h000;
    localparam logic [10:0] CCR_CIS_LIMIT     = 11'h020;

    // ------------------------------------------------------------
    // pin state register layout
    // ------------------------------------------------------------
    localparam logic [7:0] CCR_PIN_STATE_RST = 8'h0c;
    localparam logic [7:0] CCR_PIN_STATE_ONE = 8'h0c;
    localparam int         CCR_CHG_BIT       = 5;
    localparam int         CCR_RDY_BIT       = 1;

    // ------------------------------------------------------------
    // socket/copy register layout
    // ------------------------------------------------------------
    localparam logic [7:0] CCR_SOCKET_RST = 8'h00;
    localparam int         CCR_COPY_BIT   = 4;

    // ------------------------------------------------------------
    // information table contents
    // ------------------------------------------------------------
    localparam logic [7:0] CCR_TPL_DEVICE    = 8'h01;
    localparam logic [7:0] CCR_LINK_4        = 8'h04;
    localparam logic [3:0] CCR_DEV_TYPE_IO   = 4'hd;
    localparam logic       CCR_WPS_ABSENT    = 1'b1;
    localparam logic [2:0] CCR_SPEED_EXT     = 3'h7;
    localparam logic [2:0] CCR_SPEED_250NS   = 3'h1;
    localparam logic [7:0] CCR_EXT_SPEED     = 8'h4a;
    localparam logic [7:0] CCR_SIZE_2K       = 8'h01;
    localparam logic [7:0] CCR_END_MARK      = 8'hff;
    localparam logic [7:0] CCR_TPL_DEVICE_OC = 8'h1c;
    localparam logic [7:0] CCR_OC_3V_NOWAIT  = 8'h02;
    localparam logic       CCR_WPS_PRESENT   = 1'b0;
    localparam logic [7:0] CCR_TPL_JEDEC_C   = 8'h18;
    localparam logic [7:0] CCR_LINK_2        = 8'h02;
    localparam logic [7:0] CCR_UNMAPPED      = 8'h00;

endpackage

// file: tb/ccr_card_regs_props.sv
// concurrent checks on the card register block ports
`timescale 1ns/1ps
module ccr_card_regs_props
    import ccr_pkg::*;
(
    // clock, reset and host pins
    input wire logic              REF_CLK,
    input wire logic              RST,
    input wire logic [CCR_AW-1:0] ADDR,
    input wire logic              CE1_N,
    input wire logic              REG_N,
    input wire logic              OE_N,
    input wire logic [7:0]        DOUT,
    input wire logic              DOUT_OE,
    // core status and status outputs
    input wire logic              POWER_DOWN_CONTROL,
    input wire logic              POWER_STATE_REACHED,
    input wire logic              IO_MODE,
    input wire logic              CHANGE_SIGNAL_ENABLE,
    input wire logic              READY_PIN,
    input wire logic              STATUS_CHANGED_FLAG,
    input wire logic              STATUS_CHANGE_PIN_N
);
    // ------------------------------------------------------------
    // read decode and checks
    // ------------------------------------------------------------
    default clocking cb @(posedge REF_CLK); endclocking
    default disable iff (RST);
    logic rd_act;
    // raw pins; four samples cover the two sync stages and the output flop
    assign rd_act = !CE1_N && !REG_N && !OE_N;
    a_dout_idle_zero: assert property (!DOUT_OE |-> DOUT == 8'h00) else $error("data not zero while idle");
    a_rd_pin_state:
        assert property ((rd_act && ADDR == 11'h204) [*4] |-> DOUT_OE && (DOUT & 8'hdd) == 8'h0c) else $error("pin bits");
    a_rd_socket_bits:
        assert property ((rd_act && ADDR == 11'h206) [*4] |-> DOUT_OE && (DOUT & 8'hef) == 8'h00) else $error("socket");
    a_rd_cis_code:
        assert property ((rd_act && ADDR == 11'h000) [*4] |-> DOUT == 8'h01) else $error("device tuple code");
    a_rd_cis_oc:
        assert property ((rd_act && ADDR == 11'h00c) [*4] |-> DOUT == 8'h1c) else $error("conditions tuple code");
    a_busy_hold_low:
        assert property ($changed(POWER_DOWN_CONTROL) && !POWER_STATE_REACHED ##1 !POWER_STATE_REACHED [*3]
            |-> !READY_PIN) else $error("ready shown during power change");
    a_pin_mode_off:
        assert property (!(IO_MODE && CHANGE_SIGNAL_ENABLE) |=> STATUS_CHANGE_PIN_N) else $error("status pin low");
    a_pin_flag_off:
        assert property (!STATUS_CHANGED_FLAG [*2] |-> STATUS_CHANGE_PIN_N) else $error("status pin without flag");
endmodule

bind ccr_card_regs ccr_card_regs_props ccr_card_regs_props_inst (.REF_CLK(REF_CLK), .RST(RST), .ADDR(ADDR),
    .CE1_N(CE1_N), .REG_N(REG_N), .OE_N(OE_N), .DOUT(DOUT), .DOUT_OE(DOUT_OE), .IO_MODE(IO_MODE),
    .POWER_DOWN_CONTROL(POWER_DOWN_CONTROL), .POWER_STATE_REACHED(POWER_STATE_REACHED), .READY_PIN(READY_PIN),
    .CHANGE_SIGNAL_ENABLE(CHANGE_SIGNAL_ENABLE), .STATUS_CHANGED_FLAG(STATUS_CHANGED_FLAG),
    .STATUS_CHANGE_PIN_N(STATUS_CHANGE_PIN_N));

// file: tb/ccr_host_model.sv
// host socket controller model running attribute memory cycles
`timescale 1ns/1ps
module ccr_host_model
(
    // clock and returned data
    input  wire logic        clk,
    input  wire logic [7:0]  dout,
    // attribute memory pins
    output logic [10:0]      addr,
    output logic [7:0]       din,
    output logic             ce_n,
    output logic             reg_n,
    output logic             oe_n,
    output logic             we_n
);
    // ------------------------------------------------------------
    // idle pins and bus cycles
    // ------------------------------------------------------------
    initial
    begin
        addr = 11'h7ff;
        din = 8'hff;
        {ce_n, reg_n, oe_n, we_n} = 4'hf;
    end
    // strobes low five clocks; address kept three clocks past release
    task automatic rd(input logic [10:0] a, output logic [7:0] d);
        @(posedge clk);
        addr <= a;
        {ce_n, reg_n, oe_n} <= 3'b000;
        repeat (5) @(posedge clk);
        d = dout;
        {ce_n, reg_n, oe_n} <= 3'b111;
        repeat (3) @(posedge clk);
        addr <= ~a;
        @(posedge clk);
    endtask
    // write lands on the rising strobe; released lines show inverted values
    task automatic wr(input logic [10:0] a, input logic [7:0] v);
        @(posedge clk);
        addr <= a;
        din <= v;
        {ce_n, reg_n, we_n} <= 3'b000;
        repeat (4) @(posedge clk);
        we_n <= 1'b1;
        repeat (4) @(posedge clk);
        {ce_n, reg_n} <= 2'b11;
        repeat (3) @(posedge clk);
        addr <= ~a;
        din <= ~v;
    endtask
endmodule

// file: tb/ccr_card_regs_tb.sv
// self-checking bench for the card register block
`timescale 1ns/1ps
module ccr_card_regs_tb
    import ccr_pkg::*;
;
    // ------------------------------------------------------------
    // pins, instances and shared tasks
    // ------------------------------------------------------------
    logic        clk, rst, rdy, pdc, psr, iom, cse, dout_oe, ready_pin, scf, scp_n, ce_n, reg_n, oe_n, we_n;
    logic [10:0] addr;
    logic [7:0]  din, dout, d;
    int          n_fail = 0;
    int          n_tests = 0;
    ccr_card_regs ccr_card_regs_inst (.REF_CLK(clk), .RST(rst), .ADDR(addr), .DIN(din), .CE1_N(ce_n),
        .REG_N(reg_n), .OE_N(oe_n), .WE_N(we_n), .DOUT(dout), .DOUT_OE(dout_oe), .CORE_READY(rdy),
        .POWER_DOWN_CONTROL(pdc), .POWER_STATE_REACHED(psr), .IO_MODE(iom), .CHANGE_SIGNAL_ENABLE(cse),
        .READY_PIN(ready_pin), .STATUS_CHANGED_FLAG(scf), .STATUS_CHANGE_PIN_N(scp_n));
    ccr_host_model host (.clk(clk), .dout(dout), .addr(addr), .din(din), .ce_n(ce_n), .reg_n(reg_n),
        .oe_n(oe_n), .we_n(we_n));
    initial
    begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
        n_tests++;
        if (got !== exp)
        begin
            n_fail++;
            $display("Error %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic rc(input logic [10:0] a, input logic [7:0] exp);
        host.rd(a, d);
        chk($sformatf("byte at %h", a), exp, d);
    endtask
    // expected pin state: fixed ones plus change flag and readback
    function automatic logic [7:0] pv(input logic f, input logic r);
        pv = 8'h0c | {2'b00, f, 3'b000, r, 1'b0};
    endfunction
    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    task automatic t_flag;
        rc(11'h204, 8'h0c);
        rc(11'h206, 8'h00);
        rdy <= 1'b1;
        rc(11'h204, pv(1, 1));
        host.wr(11'h204, 8'h00);
        rc(11'h204, pv(0, 1));
        host.wr(11'h204, 8'h20);
        rc(11'h204, pv(1, 1));
        host.wr(11'h204, 8'h02);
        rdy <= 1'b0;
        rc(11'h204, pv(0, 0));
        host.wr(11'h204, 8'h00);
        rdy <= 1'b1;
        rc(11'h204, pv(1, 1));
        $display("pin state test done");
    endtask
    task automatic t_table;
        logic [10:0] ofs [9] = '{11'h000, 11'h002, 11'h004, 11'h008, 11'h00c, 11'h010, 11'h012, 11'h018, 11'h01a};
        logic [7:0]  val [9] = '{8'h01, 8'h04, {4'hd, 1'b1, 3'h7}, 8'h01, 8'h1c, 8'h02, 8'hd9, 8'h18, 8'h02};
        host.wr(11'h206, 8'hff); // copy number set before any mode setup
        rc(11'h206, 8'h10);
        for (int i = 0; i < 9; i++)
            rc(ofs[i], val[i]);
        host.wr(11'h000, 8'h55);
        rc(11'h000, 8'h01);
        $display("socket and table test done");
    endtask
    task automatic t_power;
        pdc <= 1'b1;
        repeat (5) @(posedge clk);
        @(negedge clk);
        chk("busy ready pin", 8'h00, {7'h00, ready_pin});
        rc(11'h204, pv(1, 0));
        psr <= 1'b1;
        iom <= 1'b1;
        cse <= 1'b1;
        @(posedge clk);
        psr <= 1'b0;
        repeat (3) @(posedge clk);
        @(negedge clk);
        chk("ready pin", 8'h01, {7'h00, ready_pin});
        chk("status pin", 8'h00, {7'h00, scp_n});
        chk("status flag", 8'h01, {7'h00, scf});
        host.wr(11'h204, 8'h00);
        @(negedge clk);
        chk("status pin idle", 8'h01, {7'h00, scp_n});
        $display("power and status test done");
    endtask
    task automatic complete_run;
        $display("comparisons %0d mismatches %0d", n_tests, n_fail);
        if (n_fail == 0 && n_tests > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    // main sequence; watchdog allows far more than the ~300 cycles needed
    initial
    begin
        rst = 1'b1;
        {rdy, pdc, psr, iom, cse} = 5'h00;
        repeat (8) @(posedge clk);
        rst <= 1'b0;
        repeat (3) @(posedge clk);
        t_flag();
        t_table();
        t_power();
        complete_run();
    end
    initial
    begin
        repeat (20000) @(posedge clk);
        n_fail++;
        complete_run();
    end
endmodule
